// file: hw/ppr_pkg.sv
// How it works
// - bits 13:8 pick odd virtual port function
// - bits 5:0 pick even virtual port function
// - bits 15:14 and 7:6 read zero, ignore writes
// - reset clears all output selector bits
// - virtual ports feed internal consumers only
// - input registers hold two 8-bit pin selectors, one in registers 0, 2, 23, 24, 27, 28, 29 and 31
package ppr_pkg;

	// register bus geometry
	localparam int ADDR_W      = 12;
	localparam int NUM_IN_SEL  = 40;

	// register byte offsets
	localparam logic [11:0] OUT_SEL_OFS = 12'h000;
	localparam logic [11:0] LOCK_OFS    = 12'h004;
	localparam logic [11:0] IN_SEL_BASE = 12'h100;

	// output selector field layout
	localparam int ODD_SEL_LSB = 8;
	localparam int EVEN_SEL_LSB = 0;
	localparam int FUNC_SEL_W  = 6;
	localparam logic [15:0] OUT_SEL_MASK = 16'h3F3F;

	// input selector field layout
	localparam int PIN_SEL_W = 8;
	localparam logic [15:0] HI_HALF_MASK = 16'hFF00;
	localparam logic [15:0] LO_HALF_MASK = 16'h00FF;

	// which halves of the 40 input registers exist, bit n = register n
	// high half missing in registers 23, 24, 27, 29 and 31
	localparam logic [39:0] HI_IMPL = 40'hFF_567F_FFFF;
	// low half missing in registers 0, 2 and 28
	localparam logic [39:0] LO_IMPL = 40'hFF_EFFF_FFFA;

	// lock control layout
	localparam int LOCK_BIT = 11;

	// reset values
	localparam logic [15:0] OUT_SEL_RST = 16'h0000;
	localparam logic [15:0] IN_SEL_RST  = 16'h0000;
	localparam logic        LOCK_RST    = 1'b0;

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// register decode result
	typedef enum logic [1:0] {
		KIND_NONE,
		KIND_OUT,
		KIND_LOCK,
		KIND_IN
	} ppr_kind_type;

	// one input selection register as two pin selectors
	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} ppr_sel_pair_type;

	// a captured write: address, low data half and its strobes
	typedef struct packed {
		logic [11:0] addr;
		logic [15:0] data;
		logic [1:0]  strb;
	} ppr_wr_req_type;

endpackage : ppr_pkg

// file: hw/ppr_sel_mux.sv
`timescale 1ns/1ps
// registered one-of-n selector; code zero or out of range gives low
module ppr_sel_mux #(
	parameter int SEL_W = 8,   // selector width
	parameter int N     = 256  // number of candidate signals
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [SEL_W-1:0] sel,
	input  wire logic [N-1:0]     din,
	output logic                  dout
);

	logic dout_next; // value for next edge

	// zero means nothing routed, so unused selectors stay quiet
	always_comb begin
		dout_next = 1'b0;
		if ((sel != '0) && (int'(sel) < N)) begin
			dout_next = din[sel];
		end
	end

	// output flop keeps the routed net glitch free
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dout <= 1'b0;
		end else begin
			dout <= dout_next;
		end
	end

endmodule : ppr_sel_mux

// file: hw/ppr_remap_top.sv
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
// pin remap selector with axi4-lite register access
module ppr_remap_top #(
	parameter int NUM_PINS  = 256, // remappable input pins
	parameter int NUM_FUNCS = 64   // peripheral output functions
) (
	input  wire logic                          CORE_CLK,
	input  wire logic                          RST_B,
	// write address channel
	input  wire logic [ppr_pkg::ADDR_W-1:0]    S_AXI_AWADDR,
	input  wire logic                          S_AXI_AWVALID,
	output logic                               S_AXI_AWREADY,
	// write data channel
	input  wire logic [31:0]                   S_AXI_WDATA,
	input  wire logic [3:0]                    S_AXI_WSTRB,
	input  wire logic                          S_AXI_WVALID,
	output logic                               S_AXI_WREADY,
	// write response channel
	output logic [1:0]                         S_AXI_BRESP,
	output logic                               S_AXI_BVALID,
	input  wire logic                          S_AXI_BREADY,
	// read address channel
	input  wire logic [ppr_pkg::ADDR_W-1:0]    S_AXI_ARADDR,
	input  wire logic                          S_AXI_ARVALID,
	output logic                               S_AXI_ARREADY,
	// read data channel
	output logic [31:0]                        S_AXI_RDATA,
	output logic [1:0]                         S_AXI_RRESP,
	output logic                               S_AXI_RVALID,
	input  wire logic                          S_AXI_RREADY,
	// remap data path
	input  wire logic [NUM_PINS-1:0]           PIN_IN,
	input  wire logic [NUM_FUNCS-1:0]          PERIPH_OUT_FUNC,
	output logic                               VIRT_PORT_EVEN,
	output logic                               VIRT_PORT_ODD,
	output logic [2*ppr_pkg::NUM_IN_SEL-1:0]   PERIPH_IN,
	output logic                               REMAP_WRITE_LOCK
);

	localparam int NSEL = ppr_pkg::NUM_IN_SEL; // input register count

	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	logic [15:0]               out_sel_reg;  // virtual port selectors
	logic [15:0]               out_sel_next;
	logic                      lock_reg;     // remap_write_lock
	logic                      lock_next;
	ppr_pkg::ppr_sel_pair_type in_sel_reg  [NSEL]; // pin selectors
	ppr_pkg::ppr_sel_pair_type in_sel_next [NSEL];

	// ---------------------------------------------------------------
	// bus handshake state
	// ---------------------------------------------------------------
	logic                    aw_full_reg;  // address captured
	logic                    aw_full_next;
	logic                    w_full_reg;   // data captured
	logic                    w_full_next;
	ppr_pkg::ppr_wr_req_type wr_req_reg;   // captured write
	ppr_pkg::ppr_wr_req_type wr_req_next;
	logic                    aw_rdy_reg;   // drives awready
	logic                    aw_rdy_next;
	logic                    w_rdy_reg;    // drives wready
	logic                    w_rdy_next;
	logic                    bvalid_reg;   // write answer pending
	logic                    bvalid_next;
	logic [1:0]              bresp_reg;
	logic [1:0]              bresp_next;
	logic                    ar_rdy_reg;   // drives arready
	logic                    ar_rdy_next;
	logic                    rvalid_reg;   // read answer pending
	logic                    rvalid_next;
	logic [31:0]             rdata_reg;
	logic [31:0]             rdata_next;
	logic [1:0]              rresp_reg;
	logic [1:0]              rresp_next;

	// decode helpers
	ppr_pkg::ppr_kind_type   wr_kind;      // target of captured write
	ppr_pkg::ppr_kind_type   rd_kind;      // target of read request
	logic [5:0]              wr_idx;       // input register index
	logic [5:0]              rd_idx;

	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------

	// map a byte address onto a register kind; low two bits ignored
	function automatic ppr_pkg::ppr_kind_type kind_of(
		input logic [ppr_pkg::ADDR_W-1:0] a
	);
		kind_of = ppr_pkg::KIND_NONE;
		if (a[11:2] == ppr_pkg::OUT_SEL_OFS[11:2]) begin
			kind_of = ppr_pkg::KIND_OUT;
		end else if (a[11:2] == ppr_pkg::LOCK_OFS[11:2]) begin
			kind_of = ppr_pkg::KIND_LOCK;
		end else if ((a[11:8] == ppr_pkg::IN_SEL_BASE[11:8]) &&
			(int'(a[7:2]) < NSEL)) begin
			kind_of = ppr_pkg::KIND_IN;
		end
	endfunction : kind_of

	// implemented bits of one input register
	function automatic logic [15:0] impl_mask(input logic [5:0] idx);
		impl_mask = 16'h0000;
		if (ppr_pkg::HI_IMPL[idx]) begin
			impl_mask = impl_mask | ppr_pkg::HI_HALF_MASK;
		end
		if (ppr_pkg::LO_IMPL[idx]) begin
			impl_mask = impl_mask | ppr_pkg::LO_HALF_MASK;
		end
	endfunction : impl_mask

	// byte-lane merge of new data into an old 16-bit word
	function automatic logic [15:0] merge(
		input logic [15:0] old_w,
		input logic [15:0] new_w,
		input logic [1:0]  strb
	);
		logic [15:0] lanes;
		lanes = {{8{strb[1]}}, {8{strb[0]}}};
		merge = (old_w & ~lanes) | (new_w & lanes);
	endfunction : merge

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	assign wr_kind = kind_of(wr_req_reg.addr);
	assign rd_kind = kind_of(S_AXI_ARADDR);
	assign wr_idx  = wr_req_reg.addr[7:2];
	assign rd_idx  = S_AXI_ARADDR[7:2];

	// ---------------------------------------------------------------
	// write path: capture address and data in either order, then
	// commit one cycle later and raise bvalid
	// ---------------------------------------------------------------
	always_comb begin
		aw_full_next = aw_full_reg;
		w_full_next  = w_full_reg;
		wr_req_next  = wr_req_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		out_sel_next = out_sel_reg;
		lock_next    = lock_reg;
		in_sel_next  = in_sel_reg;
		// address beat
		if (S_AXI_AWVALID && aw_rdy_reg) begin
			aw_full_next     = 1'b1;
			wr_req_next.addr = S_AXI_AWADDR;
		end
		// data beat; only the low half carries register bits
		if (S_AXI_WVALID && w_rdy_reg) begin
			w_full_next      = 1'b1;
			wr_req_next.data = S_AXI_WDATA[15:0];
			wr_req_next.strb = S_AXI_WSTRB[1:0];
		end
		// commit once both halves are held and no answer waits
		if (aw_full_reg && w_full_reg && !bvalid_reg) begin
			aw_full_next = 1'b0;
			w_full_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = ppr_pkg::RESP_OKAY;
			unique case (wr_kind)
				ppr_pkg::KIND_OUT: begin
					// locked writes are answered okay but dropped
					if (!lock_reg) begin
						// unimplemented pairs masked out
						out_sel_next = merge(out_sel_reg, wr_req_reg.data,
							wr_req_reg.strb) & ppr_pkg::OUT_SEL_MASK;
					end
				end
				ppr_pkg::KIND_LOCK: begin
					// the lock itself stays writable so it can be undone
					if (wr_req_reg.strb[1]) begin
						lock_next = wr_req_reg.data[ppr_pkg::LOCK_BIT];
					end
				end
				ppr_pkg::KIND_IN: begin
					if (!lock_reg) begin
						in_sel_next[wr_idx] = ppr_pkg::ppr_sel_pair_type'(
							merge(in_sel_reg[wr_idx], wr_req_reg.data,
							wr_req_reg.strb) & impl_mask(wr_idx));
					end
				end
				ppr_pkg::KIND_NONE: begin
					// unmapped address: nothing stored
					bresp_next = ppr_pkg::RESP_SLVERR;
				end
			endcase
		end else if (bvalid_reg && S_AXI_BREADY) begin
			// answer taken by the master
			bvalid_next = 1'b0;
		end
		// ready only while the slot is empty and nothing is owed
		aw_rdy_next = !aw_full_next && !bvalid_next;
		w_rdy_next  = !w_full_next && !bvalid_next;
	end

	// write path registers
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			wr_req_reg  <= '0;
			aw_rdy_reg  <= 1'b0;
			w_rdy_reg   <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= ppr_pkg::RESP_OKAY;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg  <= w_full_next;
			wr_req_reg  <= wr_req_next;
			aw_rdy_reg  <= aw_rdy_next;
			w_rdy_reg   <= w_rdy_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
		end
	end

	// register file; reset clears every selector
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			out_sel_reg <= ppr_pkg::OUT_SEL_RST;
			lock_reg    <= ppr_pkg::LOCK_RST;
			for (int i = 0; i < NSEL; i++) begin
				in_sel_reg[i] <= ppr_pkg::IN_SEL_RST;
			end
		end else begin
			out_sel_reg <= out_sel_next;
			lock_reg    <= lock_next;
			for (int i = 0; i < NSEL; i++) begin
				in_sel_reg[i] <= in_sel_next[i];
			end
		end
	end

	// ---------------------------------------------------------------
	// read path: one request at a time, answer one cycle after it
	// is taken, held until rready
	// ---------------------------------------------------------------
	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		if (S_AXI_ARVALID && ar_rdy_reg) begin
			rvalid_next = 1'b1;
			rresp_next  = ppr_pkg::RESP_OKAY;
			rdata_next  = 32'h0000_0000;
			unique case (rd_kind)
				ppr_pkg::KIND_OUT: begin
					// stored value already has zero gaps
					rdata_next[15:0] = out_sel_reg;
				end
				ppr_pkg::KIND_LOCK: begin
					rdata_next[ppr_pkg::LOCK_BIT] = lock_reg;
				end
				ppr_pkg::KIND_IN: begin
					rdata_next[15:0] = in_sel_reg[rd_idx];
				end
				ppr_pkg::KIND_NONE: begin
					// unmapped reads return zero with an error
					rresp_next = ppr_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && S_AXI_RREADY) begin
			rvalid_next = 1'b0;
		end
		// a new read is taken only once the last one is answered
		ar_rdy_next = !rvalid_next;
	end

	// read path registers
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ar_rdy_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= ppr_pkg::RESP_OKAY;
		end else begin
			ar_rdy_reg <= ar_rdy_next;
			rvalid_reg <= rvalid_next;
			rdata_reg  <= rdata_next;
			rresp_reg  <= rresp_next;
		end
	end

	// bus outputs come straight from the flops above
	assign S_AXI_AWREADY    = aw_rdy_reg;
	assign S_AXI_WREADY     = w_rdy_reg;
	assign S_AXI_BVALID     = bvalid_reg;
	assign S_AXI_BRESP      = bresp_reg;
	assign S_AXI_ARREADY    = ar_rdy_reg;
	assign S_AXI_RVALID     = rvalid_reg;
	assign S_AXI_RDATA      = rdata_reg;
	assign S_AXI_RRESP      = rresp_reg;
	assign REMAP_WRITE_LOCK = lock_reg;

	// ---------------------------------------------------------------
	// output routing: the two virtual ports have no pad, they only
	// feed other logic on the die
	// ---------------------------------------------------------------

	// even virtual port follows bits 5:0
	ppr_sel_mux #(
		.SEL_W (ppr_pkg::FUNC_SEL_W),
		.N     (NUM_FUNCS)
	) u_even_port (
		.clk   (CORE_CLK),
		.rst_b (RST_B),
		.sel   (out_sel_reg[ppr_pkg::EVEN_SEL_LSB +: ppr_pkg::FUNC_SEL_W]),
		.din   (PERIPH_OUT_FUNC),
		.dout  (VIRT_PORT_EVEN)
	);

	// odd virtual port follows bits 13:8
	ppr_sel_mux #(
		.SEL_W (ppr_pkg::FUNC_SEL_W),
		.N     (NUM_FUNCS)
	) u_odd_port (
		.clk   (CORE_CLK),
		.rst_b (RST_B),
		.sel   (out_sel_reg[ppr_pkg::ODD_SEL_LSB +: ppr_pkg::FUNC_SEL_W]),
		.din   (PERIPH_OUT_FUNC),
		.dout  (VIRT_PORT_ODD)
	);

	// ---------------------------------------------------------------
	// input routing: each selector picks one pin for a peripheral
	// input; output 2n is the low half of register n, 2n+1 the high
	// half. missing halves hold zero and so drive low.
	// ---------------------------------------------------------------
	for (genvar g = 0; g < NSEL; g++) begin : g_in
		// low half selector
		ppr_sel_mux #(
			.SEL_W (ppr_pkg::PIN_SEL_W),
			.N     (NUM_PINS)
		) u_lo (
			.clk   (CORE_CLK),
			.rst_b (RST_B),
			.sel   (in_sel_reg[g].lo),
			.din   (PIN_IN),
			.dout  (PERIPH_IN[2*g])
		);
		// high half selector
		ppr_sel_mux #(
			.SEL_W (ppr_pkg::PIN_SEL_W),
			.N     (NUM_PINS)
		) u_hi (
			.clk   (CORE_CLK),
			.rst_b (RST_B),
			.sel   (in_sel_reg[g].hi),
			.din   (PIN_IN),
			.dout  (PERIPH_IN[2*g+1])
		);
	end

endmodule : ppr_remap_top

// file: dv/ppr_remap_props.sv
`timescale 1ns/1ps
// port-level watcher for the remap block
module ppr_remap_props #(
	parameter int NUM_PINS  = 256, // remappable input pins
	parameter int NUM_FUNCS = 64   // peripheral output functions
) (
	input wire logic                         CORE_CLK,
	input wire logic                         RST_B,
	input wire logic                         S_AXI_AWVALID,
	input wire logic                         S_AXI_AWREADY,
	input wire logic                         S_AXI_WVALID,
	input wire logic                         S_AXI_WREADY,
	input wire logic [1:0]                   S_AXI_BRESP,
	input wire logic                         S_AXI_BVALID,
	input wire logic                         S_AXI_BREADY,
	input wire logic                         S_AXI_ARVALID,
	input wire logic                         S_AXI_ARREADY,
	input wire logic [31:0]                  S_AXI_RDATA,
	input wire logic                         S_AXI_RVALID,
	input wire logic                         S_AXI_RREADY,
	input wire logic [NUM_PINS-1:0]          PIN_IN,
	input wire logic [NUM_FUNCS-1:0]         PERIPH_OUT_FUNC,
	input wire logic                         VIRT_PORT_EVEN,
	input wire logic                         VIRT_PORT_ODD,
	input wire logic [2*ppr_pkg::NUM_IN_SEL-1:0] PERIPH_IN,
	input wire logic                         REMAP_WRITE_LOCK
);
	// one clock domain, so one default for all
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);

	// registers are 16 bits, the upper word half stays empty
	a_rdata_upper_zero: assert property (
		S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000) else $error("read data upper half set");
	// write answer two edges after both halves taken
	a_write_answer: assert property (
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
		else $error("write response late or missing");
	// response held until accepted
	a_bresp_hold: assert property (
		S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	// read answer one edge after the address, address port closed meanwhile
	a_read_answer: assert property (
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
		else $error("read response late");
	// read data frozen until accepted
	a_rdata_hold: assert property (
		S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data changed while waiting");
	// no function active means both virtual ports low one edge later
	a_virt_quiet: assert property (
		PERIPH_OUT_FUNC == '0 |=> !VIRT_PORT_EVEN && !VIRT_PORT_ODD)
		else $error("virtual port high with no function active");
	// all pins low means every routed input low one edge later
	a_pins_quiet: assert property (
		PIN_IN == '0 |=> PERIPH_IN == '0) else $error("peripheral input high with pins low");
	// reset leaves lock clear and both virtual ports low
	a_reset_clear: assert property (
		$rose(RST_B) |-> !REMAP_WRITE_LOCK && !VIRT_PORT_EVEN && !VIRT_PORT_ODD)
		else $error("state not cleared by reset");
endmodule : ppr_remap_props

bind ppr_remap_top ppr_remap_props #(
	.NUM_PINS  (NUM_PINS),
	.NUM_FUNCS (NUM_FUNCS)
) i_ppr_remap_props (.*);

// file: dv/tb_top.sv
`timescale 1ns/1ps
// register-level test of the pin remap selector
module tb_top;
	logic         CORE_CLK, RST_B;
	logic [11:0]  S_AXI_AWADDR, S_AXI_ARADDR;
	logic         S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
	logic [31:0]  S_AXI_WDATA, S_AXI_RDATA;
	logic [3:0]   S_AXI_WSTRB;
	logic [1:0]   S_AXI_BRESP, S_AXI_RRESP;
	logic         S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
	logic         S_AXI_RVALID, S_AXI_RREADY, VIRT_PORT_EVEN, VIRT_PORT_ODD;
	logic [255:0] PIN_IN;          // pin levels
	logic [63:0]  PERIPH_OUT_FUNC; // function levels
	logic [79:0]  PERIPH_IN;
	logic         REMAP_WRITE_LOCK;
	int           failures, num_checks, cycles; // counters
	logic [15:0]  d;                             // read value
	logic [1:0]   r;                             // response
	logic [7:0]   hi, lo;                        // input selector codes
	int           codes[4] = '{0, 1, 33, 63};   // function codes tried

	ppr_remap_top i_ppr_remap_top (.*);

	// free-running core clock
	initial begin
		CORE_CLK = 1'b0;
		forever #2.5 CORE_CLK = ~CORE_CLK;
	end

	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// write; address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [15:0] v, input logic [1:0] s);
		@(posedge CORE_CLK);
		S_AXI_AWADDR  <= a;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WDATA   <= {16'h0000, v};
		S_AXI_WSTRB   <= {2'b00, s};
		S_AXI_WVALID  <= 1'b1;
		S_AXI_BREADY  <= 1'b1;
		do begin
			@(posedge CORE_CLK);
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
		end while ((S_AXI_AWVALID && !S_AXI_AWREADY) || (S_AXI_WVALID && !S_AXI_WREADY));
		do @(posedge CORE_CLK); while (!S_AXI_BVALID);
		r = S_AXI_BRESP;
		S_AXI_BREADY <= 1'b0;
	endtask : wr

	// read; address held until taken, data taken with rvalid
	task automatic rd(input logic [11:0] a);
		@(posedge CORE_CLK);
		S_AXI_ARADDR  <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY  <= 1'b1;
		do @(posedge CORE_CLK); while (!S_AXI_ARREADY);
		S_AXI_ARVALID <= 1'b0;
		do @(posedge CORE_CLK); while (!S_AXI_RVALID);
		d = S_AXI_RDATA[15:0];
		r = S_AXI_RRESP;
		S_AXI_RREADY <= 1'b0;
	endtask : rd

	// let register update and routing stage land
	task automatic settle();
		repeat (2) @(posedge CORE_CLK);
		#1;
	endtask : settle

	// verdict, single exit
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	// hang guard, run needs a few hundred cycles
	always @(posedge CORE_CLK) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			wrap_up();
		end
	end

	initial begin
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = '0;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
		PIN_IN = '0;
		PERIPH_OUT_FUNC = '0;
		RST_B = 1'b0;
		repeat (8) @(posedge CORE_CLK);
		RST_B <= 1'b1;
		// reset values
		rd(ppr_pkg::OUT_SEL_OFS);
		chk(d, 16'h0000);
		rd(ppr_pkg::LOCK_OFS);
		chk(d, 16'h0000);
		$display("reset values done");
		// reserved bits and byte lanes
		wr(ppr_pkg::OUT_SEL_OFS, 16'hFFFF, 2'b11);
		rd(ppr_pkg::OUT_SEL_OFS);
		chk(d, 16'h3F3F);
		wr(ppr_pkg::OUT_SEL_OFS, 16'h1205, 2'b01);
		rd(ppr_pkg::OUT_SEL_OFS);
		chk(d, 16'h3F05);
		$display("output selector fields done");
		// virtual port routing over boundary codes
		PERIPH_OUT_FUNC <= 64'hA5A5_5A5A_0F0F_F0F1;
		foreach (codes[i]) begin
			wr(ppr_pkg::OUT_SEL_OFS, {2'b00, 6'(63 - codes[i]), 2'b00, 6'(codes[i])}, 2'b11);
			settle();
			chk(VIRT_PORT_EVEN, (codes[i] == 0) ? 1'b0 : PERIPH_OUT_FUNC[codes[i]]);
			chk(VIRT_PORT_ODD, (codes[i] == 63) ? 1'b0 : PERIPH_OUT_FUNC[63 - codes[i]]);
		end
		$display("virtual routing done");
		// every input register, read back and routed
		PIN_IN <= {8{32'h9E37_79B9}};
		for (int n = 0; n < ppr_pkg::NUM_IN_SEL; n++) begin
			hi = 8'(2 * n + 1);
			lo = 8'(255 - n);
			wr(12'(ppr_pkg::IN_SEL_BASE + 4 * n), {hi, lo}, 2'b11);
			settle();
			hi = ppr_pkg::HI_IMPL[n] ? hi : 8'h00;
			lo = ppr_pkg::LO_IMPL[n] ? lo : 8'h00;
			rd(12'(ppr_pkg::IN_SEL_BASE + 4 * n));
			chk(d, {hi, lo});
			chk(PERIPH_IN[2*n], (lo == 8'h00) ? 1'b0 : PIN_IN[lo]);
			chk(PERIPH_IN[2*n+1], (hi == 8'h00) ? 1'b0 : PIN_IN[hi]);
		end
		$display("input selectors done");
		// lock blocks selector writes but still answers okay
		wr(ppr_pkg::LOCK_OFS, 16'h0800, 2'b10);
		#1;
		chk(REMAP_WRITE_LOCK, 1'b1);
		wr(ppr_pkg::LOCK_OFS, 16'h0000, 2'b01);
		rd(ppr_pkg::LOCK_OFS);
		chk(d, 16'h0800);
		wr(ppr_pkg::OUT_SEL_OFS, 16'h0101, 2'b11);
		chk(r, ppr_pkg::RESP_OKAY);
		rd(ppr_pkg::OUT_SEL_OFS);
		chk(d, 16'h003F);
		wr(12'(ppr_pkg::IN_SEL_BASE + 4), 16'h0000, 2'b11);
		rd(12'(ppr_pkg::IN_SEL_BASE + 4));
		chk(d, 16'h03FE);
		wr(ppr_pkg::LOCK_OFS, 16'h0000, 2'b10);
		wr(ppr_pkg::OUT_SEL_OFS, 16'h0101, 2'b11);
		rd(ppr_pkg::OUT_SEL_OFS);
		chk(d, 16'h0101);
		$display("lock done");
		// unmapped place
		wr(12'hFF0, 16'hFFFF, 2'b11);
		chk(r, ppr_pkg::RESP_SLVERR);
		rd(12'hFF0);
		chk({r, d}, {ppr_pkg::RESP_SLVERR, 16'h0000});
		$display("unmapped done");
		// reset in mid-run, lock set first so its clearing shows
		wr(ppr_pkg::LOCK_OFS, 16'h0800, 2'b10);
		@(posedge CORE_CLK);
		RST_B <= 1'b0;
		repeat (3) @(posedge CORE_CLK);
		RST_B <= 1'b1;
		rd(ppr_pkg::OUT_SEL_OFS);
		chk(d, 16'h0000);
		chk(REMAP_WRITE_LOCK, 1'b0);
		$display("second reset done");
		wrap_up();
	end
endmodule : tb_top
